// ==== core/sarseq_top.sv ====
// Converter sequencer: enable, prescaler, conversion timing, channel
// deferral, locked result read and completion flag.
// Assumes an analog mux, sample-and-hold and comparator outside.
//
// Functional notes
// RULE_01 - Result is 10-bit unsigned built by successive approximation.
// RULE_02 - Eight single-ended channels picked by the channel select field.
// RULE_03 - Free-running bit picks single or continuous conversion.
// RULE_04 - Channel written while disabled reaches mux only once enabled.
// RULE_05 - Start write begins conversion; start reads one until done.
// RULE_06 - Channel change during conversion applies after it completes.
// RULE_07 - Software reads low result byte before high byte.
// RULE_08 - Low byte read locks results until high byte read.
// RULE_09 - Completion flag still set when a locked result is dropped.
// RULE_10 - Prescaler runs while enabled, held cleared while disabled.
// RULE_11 - Conversion begins at next converter clock rising edge.
// RULE_12 - Normal conversion lasts thirteen converter clock cycles.
// RULE_13 - First conversion after enable lasts twenty-five cycles; here a 25-cycle run precedes a normal 13-cycle one.
// RULE_14 - Sample-and-hold at 1.5 cycles normal, 13.5 extended.
// RULE_15 - Completion writes result, sets flag, clears start in single mode.
// RULE_16 - Free-running restarts at once and keeps start set.
// RULE_17 - Software keeps converter clock within 50 to 200 kHz; at 100 MHz even /128 gives 781.25 kHz.
// RULE_18 - Divide select: codes 0 and 1 give 2, doubling up to 128.
// RULE_19 - Flag cleared by vector acknowledge or writing one.
// RULE_20 - Clearing enable aborts a running conversion.
// RULE_21 - Channel code n connects input n.
// RULE_22 - Interrupt request while flag, enable and global enable set.
// RULE_23 - Writing zero to start does nothing; no restart while running.
module sarseq_top
(
  input  wire logic       sys_clk_in,             // System clock, 100 MHz
  input  wire logic       reset_n_in,             // Synchronous reset, active low
  input  wire logic       converter_enable_in,    // Converter enable bit
  input  wire logic       free_running_select_in, // Free-running mode bit
  input  wire logic       irq_enable_in,          // Completion interrupt enable
  input  wire logic       global_irq_enable_in,   // CPU global interrupt enable
  input  wire logic [2:0] clock_divide_select_in, // Prescaler select
  input  wire logic       start_write_in,         // One-cycle write of start bit
  input  wire logic       start_data_in,          // Value written to start bit
  input  wire logic       flag_write_in,          // One-cycle write of flag bit
  input  wire logic       flag_data_in,           // Value written to flag bit
  input  wire logic       irq_ack_in,             // Interrupt vector taken pulse
  input  wire logic       channel_write_in,       // One-cycle channel field write
  input  wire logic [2:0] channel_data_in,        // Channel field value
  input  wire logic       low_read_in,            // Low result byte read pulse
  input  wire logic       high_read_in,           // High result byte read pulse
  input  wire logic       cmp_high_in,            // Comparator: input above trial
  output logic            start_conversion_out,   // Start bit readback
  output logic            conversion_done_flag_out, // Completion flag
  output logic            irq_out,                // Interrupt request
  output logic [2:0]      channel_select_field_out, // Channel field readback
  output logic [2:0]      analog_mux_sel_out,     // Mux select to analog inputs
  output logic            sample_hold_out,        // Sample-and-hold strobe pulse
  output logic [9:0]      dac_trial_out,          // Trial code to the array
  output logic [7:0]      result_low_byte_out,    // Result bits 7..0
  output logic [7:0]      result_high_byte_out    // Result bits 9..8, upper zero
);

  // ****************************************
  // Prescaler and approximation register
  // ****************************************
  logic                  clk_rise;
  logic                  clk_fall;
  logic                  sar_ready;
  logic                  sar_load;
  logic                  sar_step;
  logic [9:0]            sar_trial;
  sarseq_pkg::sarseq_state_t state;
  logic [4:0]            cycle;
  logic [4:0]            conv_len;
  logic [4:0]            sh_cycle;
  logic                  extended;
  logic                  first_pending;
  logic                  locked;
  logic                  finish;
  logic                  start_req;

  sarseq_prescaler u_presc
  (
    .sys_clk_in (sys_clk_in),
    .reset_n_in (reset_n_in),
    .run_in     (converter_enable_in), // RULE_10
    .div_sel_in (clock_divide_select_in), // RULE_18
    .rise_out   (clk_rise),
    .fall_out   (clk_fall)
  );

  sarseq_sar u_sar
  (
    .sys_clk_in  (sys_clk_in),
    .reset_n_in  (reset_n_in),
    .load_in     (sar_load),
    .step_in     (sar_step),
    .cmp_high_in (cmp_high_in),
    .trial_out   (sar_trial),
    .ready_out   (sar_ready)
  );

  // Bits decided on rising edges after the hold, one per cycle
  assign sar_load = clk_fall && state == sarseq_pkg::SARSEQ_CONV && cycle == sh_cycle; // RULE_01
  assign sar_step = clk_rise && state == sarseq_pkg::SARSEQ_CONV && cycle > sh_cycle;  // RULE_01
  assign conv_len = extended ? sarseq_pkg::EXTENDED_CYCLES : sarseq_pkg::NORMAL_CYCLES;  // RULE_12 RULE_13
  assign sh_cycle = extended ? sarseq_pkg::EXTENDED_SH_CYCLE : sarseq_pkg::NORMAL_SH_CYCLE; // RULE_14
  // Last rising edge of the conversion
  assign finish   = clk_rise && state == sarseq_pkg::SARSEQ_CONV && cycle == 5'(conv_len - 5'h01); // RULE_12
  assign start_req = start_write_in && start_data_in && converter_enable_in; // RULE_23

  // ****************************************
  // Conversion sequencer
  // ****************************************
  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in || !converter_enable_in) // RULE_20
    begin
      state <= sarseq_pkg::SARSEQ_IDLE;
      cycle <= 5'h00;
    end
    else
    begin
      unique case (state)
        sarseq_pkg::SARSEQ_IDLE:
        begin
          if (start_req) // RULE_05
            state <= sarseq_pkg::SARSEQ_WAIT;
        end
        sarseq_pkg::SARSEQ_WAIT:
        begin
          if (clk_rise) // RULE_11
          begin
            state <= sarseq_pkg::SARSEQ_CONV;
            cycle <= 5'h00;
          end
        end
        sarseq_pkg::SARSEQ_CONV:
        begin
          if (finish)
          begin
            // An extended run is followed by the real one
            if (extended || free_running_select_in) // RULE_16 RULE_13
              cycle <= 5'h00;
            else
              state <= sarseq_pkg::SARSEQ_IDLE; // RULE_03
          end
          else if (clk_rise)
            cycle <= 5'(cycle + 5'h01);
        end
        default:
          state <= sarseq_pkg::SARSEQ_IDLE;
      endcase
    end
  end

  // First conversion after enable is the extended one
  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in || !converter_enable_in)
    begin
      first_pending <= 1'b1;
      extended      <= 1'b0;
    end
    else if (state == sarseq_pkg::SARSEQ_WAIT && clk_rise)
    begin
      extended      <= first_pending; // RULE_13
      first_pending <= 1'b0;
    end
    else if (finish)
      extended <= 1'b0;
  end

  // Start bit stays set through the extended run and in free-running mode
  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in || !converter_enable_in)
      start_conversion_out <= 1'b0;
    // A start on the finish edge belongs to the ending run, else the bit sticks
    else if (start_req && state == sarseq_pkg::SARSEQ_IDLE) // RULE_05 RULE_23
      start_conversion_out <= 1'b1;
    else if (finish && !extended && !free_running_select_in)
      start_conversion_out <= 1'b0; // RULE_15
  end

  // Sample strobe half a cycle after a rising edge
  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
      sample_hold_out <= 1'b0;
    else
      sample_hold_out <= sar_load; // RULE_14
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
      dac_trial_out <= sarseq_pkg::RESULT_RESET;
    else
      dac_trial_out <= sar_trial;
  end

  // ****************************************
  // Channel selection
  // ****************************************
  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
      channel_select_field_out <= sarseq_pkg::CHANNEL_RESET;
    else if (channel_write_in)
      channel_select_field_out <= channel_data_in; // RULE_02 RULE_21
  end

  // Mux follows the field only while enabled and between conversions
  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
      analog_mux_sel_out <= sarseq_pkg::CHANNEL_RESET;
    else if (converter_enable_in && (state != sarseq_pkg::SARSEQ_CONV || finish)) // RULE_04 RULE_06
      analog_mux_sel_out <= channel_select_field_out; // RULE_21
  end

  // ****************************************
  // Result registers and completion flag
  // ****************************************
  // Hazard: high byte read without a prior low read simply leaves unlocked
  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
      locked <= 1'b0;
    else if (high_read_in)
      locked <= 1'b0; // RULE_08
    else if (low_read_in)
      locked <= 1'b1; // RULE_07 RULE_08
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
    begin
      result_low_byte_out  <= 8'h00;
      result_high_byte_out <= 8'h00;
    end
    else if (finish && !extended && !locked && sar_ready) // RULE_08 RULE_15
    begin
      result_low_byte_out  <= sar_trial[7:0];
      result_high_byte_out <= {6'h00, sar_trial[9:8]};
    end
  end

  // Set wins over a same-cycle clear
  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
      conversion_done_flag_out <= 1'b0;
    else if (finish && !extended) // RULE_09 RULE_15
      conversion_done_flag_out <= 1'b1;
    else if (irq_ack_in || (flag_write_in && flag_data_in)) // RULE_19
      conversion_done_flag_out <= 1'b0;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
      irq_out <= 1'b0;
    else
      irq_out <= conversion_done_flag_out && irq_enable_in && global_irq_enable_in; // RULE_22
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_done;
    finish && !extended;
  endsequence

  a_flag_on_done: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // RULE_09
    s_done |=> conversion_done_flag_out)
    else $error("flag not set after completion");

  a_start_clears: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // RULE_15
    s_done ##0 (!free_running_select_in && converter_enable_in) |=> !start_conversion_out)
    else $error("start not cleared in single mode");

  a_free_keeps: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // RULE_16
    s_done ##0 (free_running_select_in && converter_enable_in) |=> start_conversion_out
      && state == sarseq_pkg::SARSEQ_CONV)
    else $error("free-running did not continue");

  a_lock_holds: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // RULE_08
    locked && !high_read_in |=> $stable(result_low_byte_out) && $stable(result_high_byte_out))
    else $error("result changed while locked");

  a_abort_off: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // RULE_20
    !converter_enable_in |=> state == sarseq_pkg::SARSEQ_IDLE && !start_conversion_out)
    else $error("disable did not abort");

  a_mux_hold: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // RULE_06
    state == sarseq_pkg::SARSEQ_CONV && !finish |=> $stable(analog_mux_sel_out))
    else $error("mux changed mid-conversion");

  a_mux_off: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // RULE_04
    !converter_enable_in |=> $stable(analog_mux_sel_out))
    else $error("mux changed while disabled");

  a_start_rise: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // RULE_11
    state == sarseq_pkg::SARSEQ_WAIT && clk_rise && converter_enable_in |=> state == sarseq_pkg::SARSEQ_CONV
      && cycle == 5'h00)
    else $error("conversion not begun on converter edge");

  a_irq_gate: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // RULE_22
    irq_out |-> $past(conversion_done_flag_out) && $past(irq_enable_in) && $past(global_irq_enable_in))
    else $error("irq without its causes");

  a_flag_clear: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // RULE_19
    irq_ack_in && !(finish && !extended) |=> !conversion_done_flag_out)
    else $error("flag not cleared by acknowledge");

endmodule

// ==== shared/sarseq_pkg.sv ====
// Constants for the successive-approximation converter sequencer.
// Assumes a 100 MHz system clock and a separate analog array.
package sarseq_pkg;

  localparam int          RES_BITS         = 10;
  localparam int          CHAN_BITS        = 3;
  localparam int          DIV_SEL_BITS     = 3;
  localparam int          PRESC_BITS       = 7;
  localparam int          CYC_BITS         = 5;
  localparam logic [4:0]  NORMAL_CYCLES    = 5'h0D;
  localparam logic [4:0]  EXTENDED_CYCLES  = 5'h19;
  localparam logic [4:0]  NORMAL_SH_CYCLE  = 5'h01;
  localparam logic [4:0]  EXTENDED_SH_CYCLE = 5'h0D;
  localparam logic [9:0]  RESULT_RESET     = 10'h000;
  localparam logic [2:0]  CHANNEL_RESET    = 3'h0;
  localparam logic [2:0]  DIV_SEL_RESET    = 3'h0;
  localparam logic [3:0]  SAR_BIT_TOP      = 4'h9;

  typedef enum logic [1:0]
  {
    SARSEQ_IDLE = 2'b00,
    SARSEQ_WAIT = 2'b01,
    SARSEQ_CONV = 2'b10
  } sarseq_state_t;

endpackage

// ==== core/sarseq_prescaler.sv ====
// Converter clock prescaler: one-cycle enables at the rising and falling
// edges of the divided converter clock.
// Assumes the caller holds it cleared while the converter is off.
module sarseq_prescaler
(
  input  wire logic       sys_clk_in,       // System clock
  input  wire logic       reset_n_in,       // Synchronous reset, active low
  input  wire logic       run_in,           // Count while high, clear when low
  input  wire logic [2:0] div_sel_in,       // Division select
  output logic            rise_out,         // Converter clock rising edge pulse
  output logic            fall_out          // Converter clock falling edge pulse
);

  logic [sarseq_pkg::PRESC_BITS-1:0] count;
  logic [sarseq_pkg::PRESC_BITS-1:0] next_count;
  logic [sarseq_pkg::PRESC_BITS-1:0] top;
  logic [sarseq_pkg::PRESC_BITS-1:0] half;

  // Codes 0 and 1 both divide by two
  always_comb
  begin
    if (div_sel_in == 3'h0)
      top = 7'h01;
    else
      top = 7'(({7'h00, 1'b1} << div_sel_in) - 8'h01);
    half = 7'(top >> 1);
    // A count left above a newly lowered top wraps at once, not after 128
    next_count = (count >= top) ? 7'h00 : 7'(count + 7'h01);
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in || !run_in)
    begin
      count    <= 7'h00;
      rise_out <= 1'b0;
      fall_out <= 1'b0;
    end
    else
    begin
      count    <= next_count;
      rise_out <= (count >= top);
      fall_out <= (count == half);
    end
  end

endmodule

// ==== core/sarseq_sar.sv ====
// Successive approximation register: one bit decided per step pulse.
// Assumes the comparator answer is valid when a step is taken.
module sarseq_sar
(
  input  wire logic       sys_clk_in,       // System clock
  input  wire logic       reset_n_in,       // Synchronous reset, active low
  input  wire logic       load_in,          // Begin a new approximation
  input  wire logic       step_in,          // Decide current bit
  input  wire logic       cmp_high_in,      // Input above trial level
  output logic [9:0]      trial_out,        // Trial code to the DAC
  output logic            ready_out         // All bits decided
);

  logic [3:0] bit_idx;

  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
    begin
      trial_out <= sarseq_pkg::RESULT_RESET;
      bit_idx   <= 4'h0;
      ready_out <= 1'b0;
    end
    else if (load_in)
    begin
      trial_out <= 10'h200;
      bit_idx   <= sarseq_pkg::SAR_BIT_TOP;
      ready_out <= 1'b0;
    end
    else if (step_in && !ready_out)
    begin
      trial_out[bit_idx] <= cmp_high_in;
      if (bit_idx == 4'h0)
        ready_out <= 1'b1;
      else
      begin
        trial_out[bit_idx - 4'h1] <= 1'b1;
        bit_idx <= 4'(bit_idx - 4'h1);
      end
    end
  end

endmodule

// ==== sim/sarseq_analog_model.sv ====
// Behavioural analog side: channel mux, sample-and-hold and comparator.
// Assumes the sequencer strobes the hold once per run, so twice in the first conversion after enable.
module sarseq_analog_model
(
  input  wire logic       sys_clk_in,   // System clock
  input  wire logic       reset_n_in,   // Synchronous reset, active low
  input  wire logic [2:0] mux_sel_in,   // Channel picked by the sequencer
  input  wire logic       hold_in,      // Sample-and-hold strobe
  input  wire logic [9:0] trial_in,     // Trial code from the array
  output logic            cmp_high_out  // Held input above trial
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [9:0] held;

  // ****************************************
  // Sample and compare
  // ****************************************
  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
      held <= 10'h2AA;
    else if (hold_in)
      held <= 10'h3FF - {7'h00, mux_sel_in} * 10'h05B;
  end

  // Half-LSB offset keeps an exact code from sitting on the threshold
  assign cmp_high_out = {held, 1'b1} > {trial_in, 1'b0};
endmodule

// ==== sim/tb_top.sv ====
// Self-checking bench for the converter sequencer.
// Assumes the analog model answers the comparator and a 100 MHz clock.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic       sys_clk_in, reset_n_in, converter_enable_in, free_running_select_in;
  logic       irq_enable_in, global_irq_enable_in, start_write_in, start_data_in;
  logic       flag_write_in, flag_data_in, irq_ack_in, channel_write_in;
  logic       low_read_in, high_read_in, cmp_high;
  logic [2:0] clock_divide_select_in, channel_data_in, channel_select_field_out, analog_mux_sel_out;
  logic       start_conversion_out, conversion_done_flag_out, irq_out, sample_hold_out;
  logic [9:0] dac_trial_out;
  logic [7:0] result_low_byte_out, result_high_byte_out;
  int         errors = 0;
  int         compares = 0;

  sarseq_top sarseq_top_i
  (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .converter_enable_in(converter_enable_in),
    .free_running_select_in(free_running_select_in), .irq_enable_in(irq_enable_in),
    .global_irq_enable_in(global_irq_enable_in), .clock_divide_select_in(clock_divide_select_in),
    .start_write_in(start_write_in), .start_data_in(start_data_in), .flag_write_in(flag_write_in),
    .flag_data_in(flag_data_in), .irq_ack_in(irq_ack_in), .channel_write_in(channel_write_in),
    .channel_data_in(channel_data_in), .low_read_in(low_read_in), .high_read_in(high_read_in),
    .cmp_high_in(cmp_high), .start_conversion_out(start_conversion_out),
    .conversion_done_flag_out(conversion_done_flag_out), .irq_out(irq_out),
    .channel_select_field_out(channel_select_field_out), .analog_mux_sel_out(analog_mux_sel_out),
    .sample_hold_out(sample_hold_out), .dac_trial_out(dac_trial_out),
    .result_low_byte_out(result_low_byte_out), .result_high_byte_out(result_high_byte_out)
  );

  sarseq_analog_model sarseq_analog_model_i
  (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .mux_sel_in(analog_mux_sel_out),
    .hold_in(sample_hold_out), .trial_in(dac_trial_out), .cmp_high_out(cmp_high)
  );

  always #5 sys_clk_in = ~sys_clk_in;

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask

  task automatic do_start(input logic d);
    @(posedge sys_clk_in);
    start_write_in <= 1'b1;
    start_data_in  <= d;
    @(posedge sys_clk_in);
    start_write_in <= 1'b0;
  endtask

  task automatic do_flag(input logic d);
    @(posedge sys_clk_in);
    flag_write_in <= 1'b1;
    flag_data_in  <= d;
    @(posedge sys_clk_in);
    flag_write_in <= 1'b0;
  endtask

  task automatic do_chan(input logic [2:0] ch);
    @(posedge sys_clk_in);
    channel_write_in <= 1'b1;
    channel_data_in  <= ch;
    @(posedge sys_clk_in);
    channel_write_in <= 1'b0;
  endtask

  task automatic do_read(input logic low);
    @(posedge sys_clk_in);
    low_read_in  <= low;
    high_read_in <= !low;
    @(posedge sys_clk_in);
    low_read_in  <= 1'b0;
    high_read_in <= 1'b0;
  endtask

  task automatic check_result(input logic [2:0] ch);
    logic [9:0] exp;
    exp = 10'h3FF - {7'h00, ch} * 10'h05B;
    check("low byte", {2'h0, result_low_byte_out}, {2'h0, exp[7:0]});
    check("high byte", {2'h0, result_high_byte_out}, {8'h00, exp[9:8]});
  endtask

  task automatic wait_flag(output int n);
    n = 0;
    // Look only after an edge has settled: a flag cleared just now may still read one
    do
    begin
      @(negedge sys_clk_in);
      n++;
    end
    while (conversion_done_flag_out !== 1'b1 && n < 20000);
    check("flag in time", n < 20000, 1'b1);
  endtask

  // Single conversion; mid_ch >= 0 adds a channel change and a second start
  task automatic conv(input logic ext, input int mid_ch, input int d);
    int         t_sh;
    int         t_done;
    logic [2:0] old_ch;
    t_sh   = 0;
    t_done = 0;
    do_flag(1'b1);
    old_ch = analog_mux_sel_out;
    do_start(1'b1);
    for (int n = 1; n < 20000 && t_done == 0; n++)
    begin
      @(negedge sys_clk_in);
      if (sample_hold_out === 1'b1)
        t_sh = n;
      if (conversion_done_flag_out === 1'b1)
        t_done = n;
      if (n == 4)
        check("start busy", start_conversion_out, 1'b1);
      // One negedge per pass and posedge waits fall between, so no negedge sample of the strobe is skipped
      if (n == 7 && mid_ch >= 0)
      begin
        @(posedge sys_clk_in);
        channel_write_in <= 1'b1;
        channel_data_in  <= 3'(mid_ch);
        start_write_in   <= 1'b1;
        start_data_in    <= 1'b1;
      end
      if (n == 8 && mid_ch >= 0)
      begin
        @(posedge sys_clk_in);
        channel_write_in <= 1'b0;
        start_write_in   <= 1'b0;
      end
      if (n == 30 && mid_ch >= 0)
        check("mux held", analog_mux_sel_out, old_ch);
    end
    check("length", t_done >= (ext ? 38 : 13) * d && t_done <= (ext ? 39 : 14) * d + 3, 1'b1);
    check("hold point", (2 * (t_done - t_sh) - 23 * d) inside {[-6:6]}, 1'b1);
    check("start cleared", start_conversion_out, 1'b0);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_codes();
    int d;
    @(posedge sys_clk_in);
    converter_enable_in    <= 1'b1;
    // Even /128 leaves the converter clock above the analog range; fine for a digital model
    clock_divide_select_in <= 3'h2;
    do_chan(3'h3);
    conv(1'b1, -1, 4);
    check_result(3'h3);
    for (int i = 0; i < 8; i++)
    begin
      d = (i < 2) ? 2 : (1 << i);
      @(posedge sys_clk_in);
      clock_divide_select_in <= 3'(i);
      do_chan(3'(i));
      conv(1'b0, -1, d);
      check_result(3'(i));
    end
  endtask

  task automatic test_deferred_lock();
    @(posedge sys_clk_in);
    clock_divide_select_in <= 3'h2;
    do_chan(3'h1);
    conv(1'b0, 6, 4);
    check_result(3'h1);
    settle(2);
    check("mux moved", analog_mux_sel_out, 3'h6);
    do_read(1'b1);
    do_chan(3'h5);
    conv(1'b0, -1, 4);
    check("flag locked", conversion_done_flag_out, 1'b1);
    check_result(3'h1);
    do_read(1'b0);
    conv(1'b0, -1, 4);
    check_result(3'h5);
  endtask

  task automatic test_flag_irq();
    for (int k = 0; k < 4; k++)
    begin
      @(posedge sys_clk_in);
      irq_enable_in        <= k[0];
      global_irq_enable_in <= k[1];
      settle(3);
      check("irq", irq_out, k[0] & k[1]);
    end
    do_flag(1'b0);
    settle(1);
    check("flag kept", conversion_done_flag_out, 1'b1);
    do_flag(1'b1);
    settle(2);
    check("flag write one", conversion_done_flag_out, 1'b0);
    check("irq off", irq_out, 1'b0);
    conv(1'b0, -1, 4);
    @(posedge sys_clk_in);
    irq_ack_in <= 1'b1;
    @(posedge sys_clk_in);
    irq_ack_in <= 1'b0;
    settle(1);
    check("flag ack", conversion_done_flag_out, 1'b0);
    do_start(1'b0);
    settle(100);
    check("start zero", {start_conversion_out, conversion_done_flag_out}, 2'b00);
  endtask

  task automatic test_free_abort();
    int n;
    @(posedge sys_clk_in);
    free_running_select_in <= 1'b1;
    do_start(1'b1);
    wait_flag(n);
    do_flag(1'b1);
    wait_flag(n);
    check("free spacing", n >= 48 && n <= 53, 1'b1);
    check("start kept", start_conversion_out, 1'b1);
    do_flag(1'b1);
    settle(20);
    @(posedge sys_clk_in);
    converter_enable_in <= 1'b0;
    settle(3);
    check("aborted", start_conversion_out, 1'b0);
    settle(100);
    check("no flag", conversion_done_flag_out, 1'b0);
    @(posedge sys_clk_in);
    free_running_select_in <= 1'b0;
  endtask

  task automatic test_disabled();
    do_chan(3'h2);
    do_start(1'b1);
    settle(5);
    check("field", channel_select_field_out, 3'h2);
    check("mux off", analog_mux_sel_out, 3'h5);
    check("start refused", start_conversion_out, 1'b0);
    @(posedge sys_clk_in);
    converter_enable_in <= 1'b1;
    settle(3);
    check("mux on", analog_mux_sel_out, 3'h2);
    conv(1'b1, -1, 4);
    check_result(3'h2);
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial
  begin
    sys_clk_in = 1'b0;
    {reset_n_in, converter_enable_in, free_running_select_in, irq_enable_in} = 4'h0;
    {global_irq_enable_in, start_write_in, start_data_in, flag_write_in} = 4'h0;
    {flag_data_in, irq_ack_in, channel_write_in, low_read_in, high_read_in} = 5'h00;
    clock_divide_select_in = 3'h0;
    channel_data_in        = 3'h0;
    repeat (5) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    settle(1);
    check("reset state", {start_conversion_out, conversion_done_flag_out, irq_out, analog_mux_sel_out}, 6'h00);
    test_codes();
    test_deferred_lock();
    test_flag_irq();
    test_free_abort();
    test_disabled();
    end_of_test();
  end

  initial
  begin
    #400000;
    errors++;
    end_of_test();
  end
endmodule
